// File: pkg/cpu_core_regs.vh
// Purpose: Offsets, field positions and reset values of the programming-model block
// Assumes: AHB-Lite byte addresses, 32-bit words, registers in the low bits
// Notes:   Flag positions follow the status word layout
// What this block does
// RULE1 - Eight word registers, four split into byte halves
// RULE2 - Base and index registers supply operand offsets
// RULE3 - Stack accesses always use stack segment
// RULE4 - Four segment registers: code, data, extra, stack
// RULE5 - Instruction pointer holds next sequential offset
// RULE6 - Status word layout; reserved bits read zero
// RULE7 - Overflow flag on signed result overflow
// RULE8 - Direction flag picks string index step sign
// RULE9 - Maskable interrupts taken only when enabled
// RULE10 - Trace flag raises trace interrupt per instruction
// RULE11 - Push flags first, then clear trace flag
// RULE12 - Sign flag copies result top bit
// RULE13 - Zero flag set on zero result
// RULE14 - Nibble carry from low four bits
// RULE15 - Parity flag set on even ones count
// RULE16 - Carry flag on top-bit carry or borrow
// RULE17 - Physical address is segment times sixteen plus offset
// RULE18 - Port address from immediate byte or port register
// RULE19 - Immediate port number zero-extended to sixteen bits
// RULE20 - Ports 00F8h to 00FFh are reserved
// RULE21 - Peripheral registers reached only as memory
`ifndef CPU_CORE_REGS_VH
`define CPU_CORE_REGS_VH

// Byte offsets
`define OFF_GEN_BASE    8'h00
`define OFF_BYTE_BASE   8'h20
`define OFF_SEG_BASE    8'h40
`define OFF_INSTR_PTR   8'h50
`define OFF_PSW         8'h54
`define OFF_OPERANDS    8'h58
`define OFF_COMMAND     8'h5C
`define OFF_RESULT      8'h60
`define OFF_PHYS_ADDR   8'h64
`define OFF_IO_ADDR     8'h68
`define OFF_STATUS      8'h6C
`define OFF_STACK_DATA  8'h70

// General register indices
`define IDX_PORT_INDEX  3'h2
`define IDX_BASE_REG    3'h3
`define IDX_STACK_TOP   3'h4
`define IDX_BASE_PTR    3'h5
`define IDX_SRC_INDEX   3'h6
`define IDX_DST_INDEX   3'h7

// Segment indices
`define SEG_EXTRA       2'h0
`define SEG_CODE        2'h1
`define SEG_STACK       2'h2
`define SEG_DATA        2'h3

// Status word bit positions
`define BIT_CARRY       0
`define BIT_PARITY      2
`define BIT_NIBBLE      4
`define BIT_ZERO        6
`define BIT_SIGN        7
`define BIT_TRACE       8
`define BIT_INT_EN      9
`define BIT_DIRECTION   10
`define BIT_OVERFLOW    11
`define PSW_MASK        16'h0FD5
`define PSW_RESET       16'h0000

// Command fields
`define CMD_OP_LSB      0
`define CMD_BYTE        4
`define CMD_OVR_EN      5
`define CMD_OVR_LSB     6
`define CMD_BASE_LSB    8
`define CMD_LEN_LSB     12

// Command codes
`define OP_ADD          4'h1
`define OP_ADC          4'h2
`define OP_SUB          4'h3
`define OP_SBB          4'h4
`define OP_AND          4'h5
`define OP_OR           4'h6
`define OP_XOR          4'h7
`define OP_MEMREF       4'h8
`define OP_PUSH         4'h9
`define OP_POP          4'hA
`define OP_IO_IMM       4'hB
`define OP_IO_PORT      4'hC
`define OP_STRING       4'hD
`define OP_FETCH        4'hE
`define OP_RETIRE       4'hF

// Reserved port window
`define IO_RSV_LO       16'h00F8
`define IO_RSV_HI       16'h00FF

`endif

// File: src/cpu_registers_flags_addrgen.v
// Purpose: Processor register set, flag update and address generation behind AHB-Lite
// Assumes: Single clock, single AHB-Lite master, word transfers only
// Notes:   Reads take one wait state; writes take none
//
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_core_regs.vh"

module cpu_registers_flags_addrgen (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        maskable_irq,
   output reg  [19:0] phys_addr,
   output reg         mem_strobe,
   output reg  [15:0] io_addr,
   output reg         io_strobe,
   output reg         io_reserved,
   output reg         trace_take,
   output reg         irq_take
);

   // Flip-flop storage
   reg  [15:0] gen_q [0:7];
   reg  [15:0] seg_q [0:3];
   reg  [15:0] next_instr_offset_q;
   reg  [15:0] psw_q;
   reg  [15:0] opnd_a_q;
   reg  [15:0] opnd_b_q;
   reg  [15:0] result_q;
   reg  [15:0] stack_data_q;
   reg         wr_pend_q;
   reg  [7:0]  wr_addr_q;
   reg         rd_pend_q;
   reg  [7:0]  rd_addr_q;
   reg         irq_meta_q;
   reg         irq_sync_q;
   integer     i;

   // Combinational ALU results
   reg  [15:0] alu_res;
   reg  [15:0] alu_flags;
   reg  [16:0] wide_sum;
   reg  [8:0]  narrow_sum;
   reg         alu_cin;
   reg         msb_a;
   reg         msb_b;
   reg         msb_r;

   // Command fields of the write in flight
   wire [3:0]  cmd_op     = hwdata[`CMD_OP_LSB+3:`CMD_OP_LSB];
   wire        cmd_byte   = hwdata[`CMD_BYTE];
   wire        cmd_ovr    = hwdata[`CMD_OVR_EN];
   wire [1:0]  cmd_seg    = hwdata[`CMD_OVR_LSB+1:`CMD_OVR_LSB];
   wire [2:0]  cmd_base   = hwdata[`CMD_BASE_LSB+2:`CMD_BASE_LSB];
   wire [3:0]  cmd_len    = hwdata[`CMD_LEN_LSB+3:`CMD_LEN_LSB];
   wire        addr_phase = hsel & htrans[1] & hready;
   wire        do_cmd     = wr_pend_q & (wr_addr_q == `OFF_COMMAND);

   // Segment shifted four places plus offset
   function [19:0] phys_of;
      input [15:0] seg;
      input [15:0] off;
      begin
         phys_of = {seg, 4'h0} + {4'h0, off}; // RULE17
      end
   endfunction

   // Port address from an immediate byte or a full word
   function [15:0] port_of;
      input        imm;
      input [15:0] word;
      begin
         if (imm) begin
            port_of = {8'h00, word[7:0]}; // RULE19
         end else begin
            port_of = word; // RULE18
         end
      end
   endfunction

   // Region of a byte address: 0 words, 1 byte halves, 2 segments, 3 other
   function [1:0] region_of;
      input [7:0] addr;
      begin
         if (addr[1:0] != 2'h0) begin
            region_of = 2'h3;
         end else if (addr[7:5] == 3'h0) begin
            region_of = 2'h0;
         end else if (addr[7:5] == 3'h1) begin
            region_of = 2'h1;
         end else if (addr[7:4] == 4'h4) begin
            region_of = 2'h2;
         end else begin
            region_of = 2'h3;
         end
      end
   endfunction

   // String index step, one byte or one word
   function [15:0] step_of;
      input narrow;
      begin
         if (narrow) begin
            step_of = 16'h0001;
         end else begin
            step_of = 16'h0002;
         end
      end
   endfunction

   // Operand offset from base and index registers plus displacement
   function [15:0] offset_of;
      input [2:0]  sel;
      input [15:0] base_reg;
      input [15:0] base_ptr;
      input [15:0] src;
      input [15:0] dst;
      input [15:0] disp;
      begin
         if (sel == 3'h1) begin
            offset_of = base_reg + disp; // RULE2
         end else if (sel == 3'h2) begin
            offset_of = base_ptr + disp;
         end else if (sel == 3'h3) begin
            offset_of = src + disp;
         end else if (sel == 3'h4) begin
            offset_of = dst + disp;
         end else if (sel == 3'h5) begin
            offset_of = base_reg + src + disp;
         end else if (sel == 3'h6) begin
            offset_of = base_ptr + src + disp;
         end else begin
            offset_of = disp;
         end
      end
   endfunction

   // Arithmetic and logic with flag generation
   always @* begin
      alu_res    = 16'h0000;
      alu_flags  = 16'h0000;
      alu_cin    = (cmd_op == `OP_ADC || cmd_op == `OP_SBB) ? psw_q[`BIT_CARRY] : 1'b0;
      wide_sum   = 17'h00000;
      narrow_sum = 9'h000;
      if (cmd_op == `OP_SUB || cmd_op == `OP_SBB) begin
         wide_sum   = {1'b0, opnd_a_q} - {1'b0, opnd_b_q} - {16'h0000, alu_cin};
         narrow_sum = {1'b0, opnd_a_q[7:0]} - {1'b0, opnd_b_q[7:0]} - {8'h00, alu_cin};
      end else begin
         wide_sum   = {1'b0, opnd_a_q} + {1'b0, opnd_b_q} + {16'h0000, alu_cin};
         narrow_sum = {1'b0, opnd_a_q[7:0]} + {1'b0, opnd_b_q[7:0]} + {8'h00, alu_cin};
      end
      if (cmd_op == `OP_AND) begin
         alu_res = opnd_a_q & opnd_b_q;
      end else if (cmd_op == `OP_OR) begin
         alu_res = opnd_a_q | opnd_b_q;
      end else if (cmd_op == `OP_XOR) begin
         alu_res = opnd_a_q ^ opnd_b_q;
      end else begin
         alu_res = wide_sum[15:0];
      end
      if (cmd_byte) begin
         alu_res = {8'h00, alu_res[7:0]};
      end
      msb_a = cmd_byte ? opnd_a_q[7] : opnd_a_q[15];
      msb_b = cmd_byte ? opnd_b_q[7] : opnd_b_q[15];
      msb_r = cmd_byte ? alu_res[7] : alu_res[15];
      if (cmd_op <= `OP_SBB) begin
         alu_flags[`BIT_CARRY]    = cmd_byte ? narrow_sum[8] : wide_sum[16]; // RULE16
         alu_flags[`BIT_NIBBLE]   = opnd_a_q[4] ^ opnd_b_q[4] ^ alu_res[4]; // RULE14
         if (cmd_op >= `OP_SUB) begin
            alu_flags[`BIT_OVERFLOW] = (msb_a != msb_b) && (msb_r != msb_a); // RULE7
         end else begin
            alu_flags[`BIT_OVERFLOW] = (msb_a == msb_b) && (msb_r != msb_a); // RULE7
         end
      end
      alu_flags[`BIT_SIGN]   = msb_r; // RULE12
      alu_flags[`BIT_ZERO]   = cmd_byte ? (alu_res[7:0] == 8'h00) : (alu_res == 16'h0000); // RULE13
      alu_flags[`BIT_PARITY] = ~^alu_res[7:0]; // RULE15
   end

   // Bus slave, register file and command execution
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (i = 0; i < 8; i = i + 1) begin
            gen_q[i] <= 16'h0000;
         end
         for (i = 0; i < 4; i = i + 1) begin
            seg_q[i] <= 16'h0000;
         end
         next_instr_offset_q <= 16'h0000;
         psw_q               <= `PSW_RESET;
         opnd_a_q            <= 16'h0000;
         opnd_b_q            <= 16'h0000;
         result_q            <= 16'h0000;
         stack_data_q        <= 16'h0000;
         wr_pend_q           <= 1'b0;
         wr_addr_q           <= 8'h00;
         rd_pend_q           <= 1'b0;
         rd_addr_q           <= 8'h00;
         irq_meta_q          <= 1'b0;
         irq_sync_q          <= 1'b0;
         hrdata              <= 32'h00000000;
         hreadyout           <= 1'b1;
         hresp               <= 1'b0;
         phys_addr           <= 20'h00000;
         mem_strobe          <= 1'b0;
         io_addr             <= 16'h0000;
         io_strobe           <= 1'b0;
         io_reserved         <= 1'b0;
         trace_take          <= 1'b0;
         irq_take            <= 1'b0;
      end else begin
         irq_meta_q <= maskable_irq;
         irq_sync_q <= irq_meta_q;
         mem_strobe <= 1'b0;
         io_strobe  <= 1'b0;
         trace_take <= 1'b0;
         irq_take   <= 1'b0;
         hresp      <= 1'b0;

         // Address phase capture
         wr_pend_q <= addr_phase & hwrite;
         if (addr_phase) begin
            wr_addr_q <= haddr[7:0];
            rd_addr_q <= haddr[7:0];
         end
         if (addr_phase & ~hwrite) begin
            rd_pend_q <= 1'b1;
            hreadyout <= 1'b0;
         end

         // Read data phase, one wait state
         if (rd_pend_q) begin
            rd_pend_q <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= 32'h00000000;
            if (region_of(rd_addr_q) == 2'h0) begin
               hrdata <= {16'h0000, gen_q[rd_addr_q[4:2]]};
            end else if (region_of(rd_addr_q) == 2'h1) begin
               if (rd_addr_q[4]) begin
                  hrdata <= {24'h000000, gen_q[{1'b0, rd_addr_q[3:2]}][15:8]}; // RULE1
               end else begin
                  hrdata <= {24'h000000, gen_q[{1'b0, rd_addr_q[3:2]}][7:0]}; // RULE1
               end
            end else if (region_of(rd_addr_q) == 2'h2) begin
               hrdata <= {16'h0000, seg_q[rd_addr_q[3:2]]};
            end else if (rd_addr_q == `OFF_INSTR_PTR) begin
               hrdata <= {16'h0000, next_instr_offset_q};
            end else if (rd_addr_q == `OFF_PSW) begin
               hrdata <= {16'h0000, psw_q & `PSW_MASK}; // RULE6
            end else if (rd_addr_q == `OFF_OPERANDS) begin
               hrdata <= {opnd_b_q, opnd_a_q};
            end else if (rd_addr_q == `OFF_RESULT) begin
               hrdata <= {16'h0000, result_q};
            end else if (rd_addr_q == `OFF_PHYS_ADDR) begin
               hrdata <= {12'h000, phys_addr};
            end else if (rd_addr_q == `OFF_IO_ADDR) begin
               hrdata <= {16'h0000, io_addr};
            end else if (rd_addr_q == `OFF_STATUS) begin
               hrdata <= {30'h00000000, irq_sync_q, io_reserved};
            end else if (rd_addr_q == `OFF_STACK_DATA) begin
               hrdata <= {16'h0000, stack_data_q};
            end
         end

         // Write data phase
         if (wr_pend_q) begin
            if (region_of(wr_addr_q) == 2'h0) begin
               gen_q[wr_addr_q[4:2]] <= hwdata[15:0]; // RULE1
            end else if (region_of(wr_addr_q) == 2'h1) begin
               if (wr_addr_q[4]) begin
                  gen_q[{1'b0, wr_addr_q[3:2]}][15:8] <= hwdata[7:0]; // RULE1
               end else begin
                  gen_q[{1'b0, wr_addr_q[3:2]}][7:0] <= hwdata[7:0]; // RULE1
               end
            end else if (region_of(wr_addr_q) == 2'h2) begin
               seg_q[wr_addr_q[3:2]] <= hwdata[15:0]; // RULE4
            end else if (wr_addr_q == `OFF_INSTR_PTR) begin
               next_instr_offset_q <= hwdata[15:0];
            end else if (wr_addr_q == `OFF_PSW) begin
               psw_q <= hwdata[15:0] & `PSW_MASK; // RULE6
            end else if (wr_addr_q == `OFF_OPERANDS) begin
               opnd_a_q <= hwdata[15:0];
               opnd_b_q <= hwdata[31:16];
            end
         end

         // Command execution
         if (do_cmd) begin
            if (cmd_op >= `OP_ADD && cmd_op <= `OP_XOR) begin
               result_q <= alu_res;
               psw_q    <= (psw_q & ~16'h08D5) | alu_flags;
            end else if (cmd_op == `OP_MEMREF) begin
               result_q   <= offset_of(cmd_base, gen_q[`IDX_BASE_REG], gen_q[`IDX_BASE_PTR],
                                       gen_q[`IDX_SRC_INDEX], gen_q[`IDX_DST_INDEX], opnd_a_q);
               mem_strobe <= 1'b1;
               if (cmd_ovr) begin
                  phys_addr <= phys_of(seg_q[cmd_seg], offset_of(cmd_base, gen_q[`IDX_BASE_REG],
                               gen_q[`IDX_BASE_PTR], gen_q[`IDX_SRC_INDEX], gen_q[`IDX_DST_INDEX], opnd_a_q));
               end else if (cmd_base == 3'h2 || cmd_base == 3'h6) begin
                  phys_addr <= phys_of(seg_q[`SEG_STACK], offset_of(cmd_base, gen_q[`IDX_BASE_REG],
                               gen_q[`IDX_BASE_PTR], gen_q[`IDX_SRC_INDEX], gen_q[`IDX_DST_INDEX], opnd_a_q));
               end else begin
                  phys_addr <= phys_of(seg_q[`SEG_DATA], offset_of(cmd_base, gen_q[`IDX_BASE_REG],
                               gen_q[`IDX_BASE_PTR], gen_q[`IDX_SRC_INDEX], gen_q[`IDX_DST_INDEX], opnd_a_q));
               end
            end else if (cmd_op == `OP_PUSH) begin
               gen_q[`IDX_STACK_TOP] <= gen_q[`IDX_STACK_TOP] - 16'h0002;
               phys_addr    <= phys_of(seg_q[`SEG_STACK], gen_q[`IDX_STACK_TOP] - 16'h0002); // RULE3
               stack_data_q <= opnd_a_q;
               mem_strobe   <= 1'b1;
            end else if (cmd_op == `OP_POP) begin
               gen_q[`IDX_STACK_TOP] <= gen_q[`IDX_STACK_TOP] + 16'h0002;
               phys_addr  <= phys_of(seg_q[`SEG_STACK], gen_q[`IDX_STACK_TOP]); // RULE3
               mem_strobe <= 1'b1;
            end else if (cmd_op == `OP_IO_IMM || cmd_op == `OP_IO_PORT) begin
               io_addr     <= port_of(cmd_op == `OP_IO_IMM,
                                      (cmd_op == `OP_IO_IMM) ? opnd_a_q : gen_q[`IDX_PORT_INDEX]);
               io_reserved <= (port_of(cmd_op == `OP_IO_IMM,
                                       (cmd_op == `OP_IO_IMM) ? opnd_a_q : gen_q[`IDX_PORT_INDEX])
                               >= `IO_RSV_LO) &&
                              (port_of(cmd_op == `OP_IO_IMM,
                                       (cmd_op == `OP_IO_IMM) ? opnd_a_q : gen_q[`IDX_PORT_INDEX])
                               <= `IO_RSV_HI); // RULE20
               io_strobe   <= 1'b1;
            end else if (cmd_op == `OP_STRING) begin
               phys_addr  <= phys_of(cmd_ovr ? seg_q[cmd_seg] : seg_q[`SEG_DATA], gen_q[`IDX_SRC_INDEX]);
               mem_strobe <= 1'b1;
               if (psw_q[`BIT_DIRECTION]) begin
                  gen_q[`IDX_SRC_INDEX] <= gen_q[`IDX_SRC_INDEX] - step_of(cmd_byte); // RULE8
                  gen_q[`IDX_DST_INDEX] <= gen_q[`IDX_DST_INDEX] - step_of(cmd_byte); // RULE8
               end else begin
                  gen_q[`IDX_SRC_INDEX] <= gen_q[`IDX_SRC_INDEX] + step_of(cmd_byte); // RULE8
                  gen_q[`IDX_DST_INDEX] <= gen_q[`IDX_DST_INDEX] + step_of(cmd_byte); // RULE8
               end
            end else if (cmd_op == `OP_FETCH) begin
               phys_addr  <= phys_of(seg_q[`SEG_CODE], next_instr_offset_q);
               mem_strobe <= 1'b1;
               next_instr_offset_q <= next_instr_offset_q + {12'h000, cmd_len}; // RULE5
            end else if (cmd_op == `OP_RETIRE) begin
               if (psw_q[`BIT_TRACE]) begin
                  gen_q[`IDX_STACK_TOP] <= gen_q[`IDX_STACK_TOP] - 16'h0002;
                  phys_addr    <= phys_of(seg_q[`SEG_STACK], gen_q[`IDX_STACK_TOP] - 16'h0002);
                  stack_data_q <= psw_q & `PSW_MASK; // RULE11
                  mem_strobe   <= 1'b1;
                  trace_take   <= 1'b1; // RULE10
                  psw_q[`BIT_TRACE]  <= 1'b0; // RULE11
                  psw_q[`BIT_INT_EN] <= 1'b0;
               end else if (psw_q[`BIT_INT_EN] && irq_sync_q) begin
                  gen_q[`IDX_STACK_TOP] <= gen_q[`IDX_STACK_TOP] - 16'h0002;
                  phys_addr    <= phys_of(seg_q[`SEG_STACK], gen_q[`IDX_STACK_TOP] - 16'h0002);
                  stack_data_q <= psw_q & `PSW_MASK;
                  mem_strobe   <= 1'b1;
                  irq_take     <= 1'b1; // RULE9
                  psw_q[`BIT_TRACE]  <= 1'b0;
                  psw_q[`BIT_INT_EN] <= 1'b0;
               end
            end
         end
      end
   end

   // Peripheral registers are not decoded here; they appear only on the memory address outputs
   // RULE21

endmodule
`default_nettype wire

// File: verif/cpu_registers_flags_addrgen_props.sv
// Purpose: Bus timing and output relations of the register block
// Assumes: One clock, reset active low
// Notes:   Bound to the block's top module
`timescale 1ns/1ps
`default_nettype none
`include "cpu_core_regs.vh"
module cpu_registers_flags_addrgen_props (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        maskable_irq,
   input wire logic [19:0] phys_addr,
   input wire logic        mem_strobe,
   input wire logic [15:0] io_addr,
   input wire logic        io_strobe,
   input wire logic        io_reserved,
   input wire logic        trace_take,
   input wire logic        irq_take
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   AST_HRESP_OKAY: assert property (hresp == 1'b0)
      else $error("response not okay");
   AST_RD_WAIT: assert property (hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   AST_WR_NOWAIT: assert property (hsel && htrans[1] && hwrite && hready |=> hreadyout)
      else $error("write stalled");
   AST_RDATA_HOLD: assert property ($past(hreadyout) && hreadyout |-> $stable(hrdata))
      else $error("read data moved");
   AST_IO_RSV: assert property (io_reserved == (io_addr >= `IO_RSV_LO && io_addr <= `IO_RSV_HI))
      else $error("reserved port flag wrong");
   AST_PHYS_STROBE: assert property ($changed(phys_addr) |-> mem_strobe)
      else $error("address change without strobe");
   AST_IO_STROBE: assert property ($changed(io_addr) |-> io_strobe)
      else $error("port change without strobe");
   AST_TAKE_PULSE: assert property (trace_take || irq_take |=> !trace_take && !irq_take)
      else $error("take pulse too long");
   AST_TAKE_EXCL: assert property (!(trace_take && irq_take))
      else $error("two takes at once");
   cover property (mem_strobe);
   cover property (io_strobe && io_reserved);
   cover property (trace_take);
   cover property (irq_take);
endmodule
bind cpu_registers_flags_addrgen cpu_registers_flags_addrgen_props props_u (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .maskable_irq(maskable_irq),
   .phys_addr(phys_addr), .mem_strobe(mem_strobe), .io_addr(io_addr),
   .io_strobe(io_strobe), .io_reserved(io_reserved), .trace_take(trace_take),
   .irq_take(irq_take));
`default_nettype wire

// File: verif/cpu_registers_flags_addrgen_tb.sv
// Purpose: Register, flag and address checks over the bus
// Assumes: One bus master, word transfers
// Notes:   Expected values worked out by hand
`timescale 1ns/1ps
`default_nettype none
`include "cpu_core_regs.vh"
module cpu_registers_flags_addrgen_tb;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        maskable_irq = 1'b0;
   logic [31:0] rd;
   wire  [31:0] hrdata;
   wire  [19:0] phys_addr;
   wire  [15:0] io_addr;
   wire         hreadyout, hresp, mem_strobe, io_strobe, io_reserved, trace_take, irq_take;
   int          error_cnt = 0, checks = 0, cyc = 0, trace_cnt = 0, irq_cnt = 0, mem_cnt = 0, io_cnt = 0;
   logic [15:0] ta [0:6] = '{16'h7FFF, 16'hFFFF, 16'h0000, 16'h8000, 16'hF0F0, 16'h8001, 16'h1234};
   logic [15:0] tb [0:6] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0F0F, 16'h0002, 16'h0000};
   logic [15:0] tr [0:6] = '{16'h8000, 16'h0000, 16'hFFFF, 16'h7FFE, 16'h0000, 16'h8003, 16'h1234};
   logic [15:0] tp [0:6] = '{16'h0894, 16'h0055, 16'h0095, 16'h0810, 16'h0044, 16'h0084, 16'h0000};

   cpu_registers_flags_addrgen dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .maskable_irq(maskable_irq),
      .phys_addr(phys_addr), .mem_strobe(mem_strobe), .io_addr(io_addr),
      .io_strobe(io_strobe), .io_reserved(io_reserved), .trace_take(trace_take),
      .irq_take(irq_take));

   always #4 hclk = ~hclk;

   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (trace_take === 1'b1) trace_cnt <= trace_cnt + 1;
      if (irq_take === 1'b1) irq_cnt <= irq_cnt + 1;
      if (mem_strobe === 1'b1) mem_cnt <= mem_cnt + 1;
      if (io_strobe === 1'b1) io_cnt <= io_cnt + 1;
      if (cyc == 5000) begin
         error_cnt = error_cnt + 1;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Address phase held until ready, then data phase until ready
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic run(input logic [31:0] ops, input logic [31:0] c);
      wr(`OFF_OPERANDS, ops);
      wr(`OFF_COMMAND, c);
   endtask

   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rc(`OFF_PSW, 32'h0);
      rc(8'hFC, 32'h0);
      wr(`OFF_PSW, 32'hFFFF);
      rc(`OFF_PSW, 32'h0FD5);
      wr(`OFF_PSW, 32'h0);
      wr(`OFF_GEN_BASE, 32'h1234);
      rc(`OFF_BYTE_BASE, 32'h34);
      wr(8'h30, 32'hAB);
      rc(`OFF_GEN_BASE, 32'hAB34);
      for (int i = 0; i < 7; i++) begin
         run({tb[i], ta[i]}, 32'(i + 1));
         rc(`OFF_RESULT, {16'h0, tr[i]});
         rc(`OFF_PSW, {16'h0, tp[i]});
      end
      wr(8'h4C, 32'h12A4);
      wr(8'h48, 32'h2000);
      wr(8'h0C, 32'h0010);
      wr(8'h14, 32'h0100);
      run(32'h0022, 32'h0008);
      rc(`OFF_PHYS_ADDR, 32'h12A62);
      run(32'h0022, 32'h0108);
      rc(`OFF_RESULT, 32'h0032);
      rc(`OFF_PHYS_ADDR, 32'h12A72);
      run(32'h0022, 32'h0208);
      rc(`OFF_PHYS_ADDR, 32'h20122);
      run(32'h0022, 32'h02E8);
      rc(`OFF_PHYS_ADDR, 32'h12B62);
      wr(8'h10, 32'h0100);
      run(32'hBEEF, 32'h00E9);
      rc(`OFF_PHYS_ADDR, 32'h200FE);
      rc(`OFF_STACK_DATA, 32'hBEEF);
      run(32'h0, 32'h000A);
      rc(`OFF_PHYS_ADDR, 32'h200FE);
      rc(8'h10, 32'h0100);
      run(32'h12F8, 32'h000B);
      rc(`OFF_IO_ADDR, 32'h00F8);
      rc(`OFF_STATUS, 32'h1);
      wr(8'h08, 32'h1234);
      run(32'h0, 32'h000C);
      rc(`OFF_IO_ADDR, 32'h1234);
      rc(`OFF_STATUS, 32'h0);
      wr(8'h18, 32'h0010);
      wr(8'h1C, 32'h0020);
      run(32'h0, 32'h000D);
      rc(`OFF_PHYS_ADDR, 32'h12A50);
      rc(8'h18, 32'h0012);
      wr(`OFF_PSW, 32'h0400);
      run(32'h0, 32'h001D);
      rc(8'h18, 32'h0011);
      rc(8'h1C, 32'h0021);
      wr(8'h44, 32'h1000);
      wr(`OFF_INSTR_PTR, 32'h0010);
      run(32'h0, 32'h300E);
      rc(`OFF_PHYS_ADDR, 32'h10010);
      rc(`OFF_INSTR_PTR, 32'h0013);
      wr(`OFF_PSW, 32'h0300);
      run(32'h0, 32'h000F);
      rc(`OFF_STACK_DATA, 32'h0300);
      rc(`OFF_PSW, 32'h0);
      rc(8'h10, 32'h00FE);
      chk(32'(trace_cnt), 32'h1);
      maskable_irq <= 1'b1;
      wr(`OFF_PSW, 32'h0200);
      repeat (4) @(posedge hclk);
      rc(`OFF_STATUS, 32'h2);
      run(32'h0, 32'h000F);
      rc(`OFF_PSW, 32'h0);
      run(32'h0, 32'h000F);
      chk(32'(irq_cnt), 32'h1);
      chk(32'(mem_cnt), 32'h0000000B);
      chk(32'(io_cnt), 32'h2);
      report_and_stop();
   end
endmodule
`default_nettype wire
